// [hw/dec_consts.vh]
// Constants shared by the diagnostic event classifier design files
`ifndef DEC_CONSTS_VH
`define DEC_CONSTS_VH

// ----------------------------------------------------------------
// Fault count and field widths
// ----------------------------------------------------------------
`define DEC_NUM_FAULTS 40
`define DEC_NUM_W 6
`define DEC_LIMIT_W 16

// ----------------------------------------------------------------
// Error type codes
// ----------------------------------------------------------------
`define DEC_TYPE_NONE 3'h0
`define DEC_TYPE_SENSOR 3'h1
`define DEC_TYPE_PLANT 3'h2
`define DEC_TYPE_HANDLING 3'h4

// ----------------------------------------------------------------
// Maintenance classes
// ----------------------------------------------------------------
`define DEC_CLASS_NONE 3'h0
`define DEC_CLASS_FAILURE 3'h1
`define DEC_CLASS_MAINT 3'h2
`define DEC_CLASS_CHECK 3'h3
`define DEC_CLASS_OUTSPEC 3'h4

// ----------------------------------------------------------------
// Attribution codes, bit 0 internal and bit 1 external
// ----------------------------------------------------------------
`define DEC_ATTR_INT 2'h1
`define DEC_ATTR_EXT 2'h2
`define DEC_ATTR_BOTH 2'h3

// ----------------------------------------------------------------
// Event identifier upper parts
// ----------------------------------------------------------------
`define DEC_ID_SENSOR_FAIL 24'hF56010
`define DEC_ID_SENSOR_MAINT 24'hFD6010
`define DEC_ID_PLANT 24'hF96010
`define DEC_ID_HANDLING 24'hF76010

// ----------------------------------------------------------------
// Fault vector indices (fault number minus one)
// ----------------------------------------------------------------
`define DEC_IDX_EMPTY_LINE 26
`define DEC_IDX_ZERO_SPREAD 28
`define DEC_IDX_ZERO_OFFSET 29
`define DEC_IDX_LOST_IRQ 35

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DEC_OFS_CTRL 6'h00
`define DEC_OFS_STATUS 6'h04
`define DEC_OFS_FAULTS_LO 6'h08
`define DEC_OFS_FAULTS_HI 6'h0C
`define DEC_OFS_REPORT 6'h10
`define DEC_OFS_REPORT_ID 6'h14
`define DEC_OFS_EMPTY_LIMIT 6'h18
`define DEC_OFS_SPREAD_LIMIT 6'h1C
`define DEC_OFS_OFFSET_LIMIT 6'h20

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define DEC_CTRL_ENABLE 0
`define DEC_CTRL_CLR_LOST 1
`define DEC_CTRL_RESET 1'h1
`define DEC_EMPTY_LIMIT_RESET 16'h0000
`define DEC_ZERO_LIMIT_RESET 16'hFFFF
`define DEC_REP_COMING 31

`endif

// [hw/dec_sync.v]
// Two-stage synchroniser for a vector of fault levels
`timescale 1ns/100ps
`default_nettype none

module dec_sync #(
    parameter WIDTH = 40
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Level vector
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // ----------------------------------------------------------------
    // Synchroniser stages
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] stage_a; // First stage, read by stage_b only
    reg [WIDTH-1:0] stage_b; // Second stage, safe to use

    // Both stages clear on reset so no phantom faults appear
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            stage_a <= {WIDTH{1'b0}};
            stage_b <= {WIDTH{1'b0}};
        end else begin
            stage_a <= async_in;
            stage_b <= stage_a;
        end
    end

    assign sync_out = stage_b;

endmodule // dec_sync

`default_nettype wire

// [hw/dec_attr.v]
// Attribute lookup: type, class, attribution and event id per fault number
`timescale 1ns/100ps
`default_nettype none
`include "dec_consts.vh"

module dec_attr (
    // Fault number, 1 to 40
    input wire [5:0] num_in,
    // Attributes
    output reg [2:0] type_out,
    output reg [2:0] class_out,
    output reg [1:0] attr_out,
    output reg [31:0] id_out
);

    // ----------------------------------------------------------------
    // Lookup table, a pure decode of the number
    // ----------------------------------------------------------------
    always @* begin
        type_out = `DEC_TYPE_SENSOR;
        class_out = `DEC_CLASS_FAILURE;
        attr_out = `DEC_ATTR_INT;
        id_out = {`DEC_ID_SENSOR_FAIL, 2'h0, num_in};
        if (num_in >= 6'h0D && num_in <= 6'h10) begin
            // Sensor memory faults
            class_out = `DEC_CLASS_MAINT;
            attr_out = `DEC_ATTR_BOTH;
            id_out = {`DEC_ID_SENSOR_MAINT, 2'h0, num_in};
        end else if (num_in == 6'h27 || num_in == 6'h28) begin
            // Link and supply faults
            class_out = `DEC_CLASS_MAINT;
            attr_out = `DEC_ATTR_BOTH;
            id_out = {`DEC_ID_SENSOR_MAINT, 2'h0, num_in};
        end else if (num_in == 6'h11) begin
            // Transmitter overheating
            class_out = `DEC_CLASS_MAINT;
        end else if (num_in >= 6'h13 && num_in <= 6'h1E) begin
            // Plant condition faults, all external
            type_out = `DEC_TYPE_PLANT;
            attr_out = `DEC_ATTR_EXT;
            id_out = {`DEC_ID_PLANT, 2'h0, num_in};
            if (num_in <= 6'h18) begin
                class_out = `DEC_CLASS_CHECK;
            end else if (num_in <= 6'h1A) begin
                class_out = `DEC_CLASS_MAINT;
            end else begin
                class_out = `DEC_CLASS_OUTSPEC;
            end
        end else if (num_in == 6'h1F) begin
            // Totalizer setup value error
            class_out = `DEC_CLASS_OUTSPEC;
            attr_out = `DEC_ATTR_EXT;
        end
    end

endmodule // dec_attr

`default_nettype wire

// [hw/dec_top.v]
// Diagnostic event classifier: fault tracking, event reports and register slave
//
// Contract
// - Type code: 0 none, 1 sensor, 2 plant, 4 handling
// - Fault onset reported with report MSB set
// - Fault removal reported with report MSB cleared
// - Handling faults are single events, never cleared
// - Sensor faults internal, raise group fault indication
// - Plant faults external, raise group fault indication
// - Handling faults external, no lamp lit
// - Class: 1 failure, 2 maintenance, 3 check, 4 outspec
// - Sensor fault lights sensor lamp and summary bit
// - Plant fault lights plant lamp and summary bit
// - Failure sensor faults use F56010 plus number
// - Faults 13-16, 39, 40: maintenance, both, FD6010
// - Overheating: maintenance, internal, identifier ending 11
// - Faults 19-30 external, F96010, classes by range
// - Empty line when density below threshold
// - Zero spread and zero offset limit faults
// - Totalizer setup: outspec, external, ends 1F
// - Restart, code, lost interrupt, parameter, lifebit failures
// - Fault flag reads one while fault present
// - Lost interrupt when report still unread
`timescale 1ns/100ps
`default_nettype none
`include "dec_consts.vh"

module dec_top #(
    parameter NUM_FAULTS = 40,
    parameter LIMIT_W = 16
) (
    // Clock and reset
    input wire CLK_IN,
    input wire RST_B_IN,
    // Fault levels from detection logic, asynchronous
    input wire [NUM_FAULTS-1:0] FAULT_IN,
    // Measurements, same clock
    input wire [LIMIT_W-1:0] DENSITY_IN,
    input wire [LIMIT_W-1:0] ZERO_SPREAD_IN,
    input wire [LIMIT_W-1:0] ZERO_OFFSET_IN,
    // Handling fault events, same clock
    input wire HANDLING_EVT_IN,
    input wire [5:0] HANDLING_CODE_IN,
    // Avalon-MM slave
    input wire [3:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    output wire [31:0] AVS_READDATA_OUT,
    output wire AVS_WAITREQUEST_OUT,
    // Lamps and summary indications
    output wire SENSOR_LAMP_OUT,
    output wire PLANT_LAMP_OUT,
    output wire GROUP_FAULT_OUT,
    output wire REPORT_PENDING_OUT
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Lowest index where two vectors differ; bit 6 is the found flag
    function [6:0] dec_first_diff;
        input [NUM_FAULTS-1:0] diff;
        integer k;
        begin
            dec_first_diff = 7'h00;
            for (k = NUM_FAULTS - 1; k >= 0; k = k - 1) begin
                if (diff[k]) begin
                    dec_first_diff = {1'b1, k[5:0]};
                end
            end
        end
    endfunction

    // Byte lane merge of a write into a stored limit, sized to the limit
    function [LIMIT_W-1:0] dec_merge;
        input [LIMIT_W-1:0] old_word;
        input [31:0] new_word;
        input [3:0] lanes;
        integer b;
        begin
            dec_merge = old_word;
            for (b = 0; b < LIMIT_W / 8; b = b + 1) begin
                if (lanes[b]) begin
                    dec_merge[b*8 +: 8] = new_word[b*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wire [NUM_FAULTS-1:0] pin_fault; // Synchronised fault levels
    wire [NUM_FAULTS-1:0] cur_fault; // Present fault state
    reg [NUM_FAULTS-1:0] seen_fault; // Last state already reported
    reg [NUM_FAULTS-1:0] sensor_mask; // Faults typed as sensor faults
    reg lost_irq; // Sticky lost-interrupt fault
    reg report_enable; // Software enable for reports
    reg [LIMIT_W-1:0] empty_limit; // Empty line density threshold
    reg [LIMIT_W-1:0] spread_limit; // Zero spread limit
    reg [LIMIT_W-1:0] offset_limit; // Zero offset limit
    reg empty_line; // Comparator results, registered
    reg zero_spread;
    reg zero_offset;
    reg sensor_lamp; // Lamp and summary flip-flops
    reg plant_lamp;
    reg group_fault;
    reg pending; // A report waits for the host
    reg [31:0] rep_word; // Held report word
    reg [31:0] rep_id; // Held event identifier
    reg ack; // Second cycle of a bus access
    reg [31:0] rdata; // Registered read data
    wire [6:0] first; // Scan result
    wire [5:0] scan_num; // Fault number of scan result
    wire [2:0] scan_type;
    wire [2:0] scan_class;
    wire [1:0] scan_attr;
    wire [31:0] scan_id;
    wire [5:0] byte_addr; // Byte address of access
    wire bus_req; // Any access
    wire bus_done; // Access completes at this edge
    wire wr_done; // Write completes
    wire pop; // Host consumes the held report
    wire slot_free; // Report slot free this cycle
    wire clr_lost; // Software clears lost-interrupt fault
    integer i;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    dec_sync #(
        .WIDTH(NUM_FAULTS)
    ) u_sync (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .async_in(FAULT_IN),
        .sync_out(pin_fault)
    );

    // ----------------------------------------------------------------
    // Present fault state
    // ----------------------------------------------------------------

    // Internally judged faults replace their pin bits
    genvar g;
    generate
        for (g = 0; g < NUM_FAULTS; g = g + 1) begin : g_cur
            if (g == `DEC_IDX_EMPTY_LINE) begin : g_empty
                assign cur_fault[g] = empty_line;
            end else if (g == `DEC_IDX_ZERO_SPREAD) begin : g_spread
                assign cur_fault[g] = zero_spread;
            end else if (g == `DEC_IDX_ZERO_OFFSET) begin : g_offset
                assign cur_fault[g] = zero_offset;
            end else if (g == `DEC_IDX_LOST_IRQ) begin : g_lost
                assign cur_fault[g] = lost_irq;
            end else begin : g_pin
                assign cur_fault[g] = pin_fault[g];
            end
        end
    endgenerate

    // Limit comparators, registered to keep timing short
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            empty_line <= 1'b0;
            zero_spread <= 1'b0;
            zero_offset <= 1'b0;
        end else begin
            empty_line <= (DENSITY_IN < empty_limit);
            zero_spread <= (ZERO_SPREAD_IN > spread_limit);
            zero_offset <= (ZERO_OFFSET_IN > offset_limit);
        end
    end

    // ----------------------------------------------------------------
    // Type mask and lamps
    // ----------------------------------------------------------------

    // Sensor faults are 1 to 18 and 31 to 40, the rest are plant faults
    always @* begin
        for (i = 0; i < NUM_FAULTS; i = i + 1) begin
            sensor_mask[i] = (i < 18) || (i > 29);
        end
    end

    // Lamps follow the live state, so they clear with the last fault
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            sensor_lamp <= 1'b0;
            plant_lamp <= 1'b0;
            group_fault <= 1'b0;
        end else begin
            sensor_lamp <= |(cur_fault & sensor_mask);
            plant_lamp <= |(cur_fault & ~sensor_mask);
            group_fault <= |cur_fault;
        end
    end

    // ----------------------------------------------------------------
    // Transition scan and attribute lookup
    // ----------------------------------------------------------------
    assign first = dec_first_diff(cur_fault ^ seen_fault);
    assign scan_num = first[5:0] + 6'h01;

    dec_attr u_attr (
        .num_in(scan_num),
        .type_out(scan_type),
        .class_out(scan_class),
        .attr_out(scan_attr),
        .id_out(scan_id)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign byte_addr = {AVS_ADDRESS_IN, 2'b00};
    assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
    assign bus_done = bus_req & ack;
    assign wr_done = AVS_WRITE_IN & ack;
    assign pop = AVS_READ_IN & ack & (byte_addr == `DEC_OFS_REPORT);
    assign clr_lost = wr_done && (byte_addr == `DEC_OFS_CTRL) && AVS_BYTEENABLE_IN[0]
        && AVS_WRITEDATA_IN[`DEC_CTRL_CLR_LOST];
    assign slot_free = ~pending | pop;

    // Every access waits exactly one cycle, then completes
    assign AVS_WAITREQUEST_OUT = bus_req & ~ack;

    // Wait-state flag and read data capture
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
        end else if (bus_done) begin
            ack <= 1'b0;
        end else if (bus_req) begin
            ack <= 1'b1;
            case (byte_addr)
                `DEC_OFS_CTRL: rdata <= {31'h00000000, report_enable};
                `DEC_OFS_STATUS: rdata <= {28'h0000000, pending, group_fault, plant_lamp, sensor_lamp};
                `DEC_OFS_FAULTS_LO: rdata <= cur_fault[31:0];
                `DEC_OFS_FAULTS_HI: rdata <= {24'h000000, cur_fault[NUM_FAULTS-1:32]};
                `DEC_OFS_REPORT: rdata <= rep_word;
                `DEC_OFS_REPORT_ID: rdata <= rep_id;
                `DEC_OFS_EMPTY_LIMIT: rdata <= {16'h0000, empty_limit};
                `DEC_OFS_SPREAD_LIMIT: rdata <= {16'h0000, spread_limit};
                `DEC_OFS_OFFSET_LIMIT: rdata <= {16'h0000, offset_limit};
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    assign AVS_READDATA_OUT = rdata;

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------

    // Writes take effect at the completing edge only
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            report_enable <= `DEC_CTRL_RESET;
            empty_limit <= `DEC_EMPTY_LIMIT_RESET;
            spread_limit <= `DEC_ZERO_LIMIT_RESET;
            offset_limit <= `DEC_ZERO_LIMIT_RESET;
        end else if (wr_done) begin
            case (byte_addr)
                `DEC_OFS_CTRL: begin
                    if (AVS_BYTEENABLE_IN[0]) begin
                        report_enable <= AVS_WRITEDATA_IN[`DEC_CTRL_ENABLE];
                    end
                end
                `DEC_OFS_EMPTY_LIMIT: begin
                    empty_limit <= dec_merge(empty_limit, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                end
                `DEC_OFS_SPREAD_LIMIT: begin
                    spread_limit <= dec_merge(spread_limit, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                end
                `DEC_OFS_OFFSET_LIMIT: begin
                    offset_limit <= dec_merge(offset_limit, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
                end
                default: begin
                    // Read-only or unmapped, write ignored
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Lost interrupt fault
    // ----------------------------------------------------------------

    // A handling event finding the slot busy is lost; set beats clear
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            lost_irq <= 1'b0;
        end else if (HANDLING_EVT_IN && report_enable && !slot_free) begin
            lost_irq <= 1'b1;
        end else if (clr_lost) begin
            lost_irq <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Report generation
    // ----------------------------------------------------------------

    // Handling events take the slot first; they cannot wait, level
    // changes can since the scan finds them again next cycle
    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            pending <= 1'b0;
            rep_word <= 32'h00000000;
            rep_id <= 32'h00000000;
            seen_fault <= {NUM_FAULTS{1'b0}};
        end else if (!report_enable) begin
            // Track silently so enabling gives no burst of stale changes
            seen_fault <= cur_fault;
            if (pop) begin
                pending <= 1'b0;
            end
        end else if (slot_free && HANDLING_EVT_IN) begin
            pending <= 1'b1;
            // Event only, no going report ever follows
            rep_word <= {1'b1, 12'h000, `DEC_TYPE_HANDLING, 1'b0, `DEC_CLASS_CHECK,
                2'b00, `DEC_ATTR_EXT, 2'b00, HANDLING_CODE_IN};
            rep_id <= {`DEC_ID_HANDLING, 2'b00, HANDLING_CODE_IN};
        end else if (slot_free && first[6]) begin
            pending <= 1'b1;
            seen_fault[first[5:0]] <= cur_fault[first[5:0]];
            // Onset sets the top bit, removal clears it
            rep_word <= {cur_fault[first[5:0]], 12'h000, scan_type, 1'b0, scan_class,
                2'b00, scan_attr, 2'b00, scan_num};
            rep_id <= scan_id;
        end else if (pop) begin
            pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign SENSOR_LAMP_OUT = sensor_lamp;
    assign PLANT_LAMP_OUT = plant_lamp;
    assign GROUP_FAULT_OUT = group_fault;
    assign REPORT_PENDING_OUT = pending;

endmodule // dec_top

`default_nettype wire

// [verif/dec_top_monitor.sv]
// Port-level property checker for the event classifier
`timescale 1ns/100ps
`default_nettype none
module dec_monitor #(
    parameter NUM_FAULTS = 40
) (
    // Clock, reset and stimulus seen
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [NUM_FAULTS-1:0] FAULT_IN,
    input wire logic HANDLING_EVT_IN,
    input wire logic AVS_READ_IN,
    // Outputs watched
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic SENSOR_LAMP_OUT,
    input wire logic PLANT_LAMP_OUT,
    input wire logic GROUP_FAULT_OUT,
    input wire logic REPORT_PENDING_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    // One wait state on every read
    property p_rd_wait; $rose(AVS_READ_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_sen_grp; SENSOR_LAMP_OUT |-> GROUP_FAULT_OUT; endproperty
    a_sen_grp: assert property (p_sen_grp) else $error("sensor lamp without group");
    property p_pla_grp; PLANT_LAMP_OUT |-> GROUP_FAULT_OUT; endproperty
    a_pla_grp: assert property (p_pla_grp) else $error("plant lamp without group");
    // Handling events never light a lamp, so group implies a lamp
    property p_grp_lamp; GROUP_FAULT_OUT |-> SENSOR_LAMP_OUT || PLANT_LAMP_OUT; endproperty
    a_grp_lamp: assert property (p_grp_lamp) else $error("group without lamp");
    property p_sen_lamp; $rose(FAULT_IN[0]) |-> ##3 SENSOR_LAMP_OUT; endproperty
    a_sen_lamp: assert property (p_sen_lamp) else $error("sensor lamp late");
    property p_pla_lamp; $rose(FAULT_IN[18]) |-> ##3 PLANT_LAMP_OUT; endproperty
    a_pla_lamp: assert property (p_pla_lamp) else $error("plant lamp late");
    property p_come; $rose(FAULT_IN[1]) && !REPORT_PENDING_OUT |-> ##[1:6] REPORT_PENDING_OUT; endproperty
    a_come: assert property (p_come) else $error("no report on onset");
    property p_hand; HANDLING_EVT_IN && !REPORT_PENDING_OUT |=> REPORT_PENDING_OUT; endproperty
    a_hand: assert property (p_hand) else $error("handling event not held");
    property p_idle; !AVS_READ_IN && $past(AVS_WAITREQUEST_OUT) |-> $stable(SENSOR_LAMP_OUT) || FAULT_IN != 0 || !SENSOR_LAMP_OUT; endproperty
    a_idle: assert property (p_idle) else $error("sensor lamp stuck");
endmodule // dec_monitor
`default_nettype wire

// [verif/dec_host_model.sv]
// Host model: Avalon-MM master issuing single word transfers
`timescale 1ns/100ps
`default_nettype none
module dec_host (
    // Bus answer
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    input wire logic wait_in,
    // Bus request
    output var logic [3:0] addr_out,
    output var logic rd_out,
    output var logic wr_out,
    output var logic [31:0] wdata_out,
    output var logic timeout_out
);
    initial begin
        addr_out = 4'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        timeout_out = 1'b0;
    end
    // Request held until waitrequest sampled low; bounded so a dead slave cannot hang us
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        int i;
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= wd;
        rd_out <= !w;
        wr_out <= w;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_in);
            if (wait_in === 1'b0) break;
        end
        d = rdata_in;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        if (i == 40) timeout_out = 1'b1;
    endtask
endmodule // dec_host
`default_nettype wire

// [verif/dec_top_tb.sv]
// Self-checking bench for the event classifier
`timescale 1ns/100ps
`default_nettype none
module dec_top_tb;
    logic clk, rst_b, h_evt, rd, wr, waitreq, s_lamp, p_lamp, grp, pend, host_to;
    logic [39:0] fault;
    logic [15:0] dens, spread, offs;
    logic [5:0] h_code;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    int miscompares = 0;
    int samples_checked = 0;
    dec_top dut_u (.CLK_IN(clk), .RST_B_IN(rst_b), .FAULT_IN(fault), .DENSITY_IN(dens),
        .ZERO_SPREAD_IN(spread), .ZERO_OFFSET_IN(offs), .HANDLING_EVT_IN(h_evt),
        .HANDLING_CODE_IN(h_code), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq), .SENSOR_LAMP_OUT(s_lamp), .PLANT_LAMP_OUT(p_lamp),
        .GROUP_FAULT_OUT(grp), .REPORT_PENDING_OUT(pend));
    dec_host host_u (.clk_in(clk), .rdata_in(rdata), .wait_in(waitreq), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdata), .timeout_out(host_to));
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus access; a stalled slave ends the run
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        host_u.xfer(w, a, wd, d);
        if (host_to === 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // Expected {event id, report word} from the fault number
    function automatic logic [63:0] exp_rep(input int n, input logic c);
        logic pl, mb;
        logic [2:0] cl;
        logic [1:0] at;
        logic [23:0] pre;
        pl = (n >= 19) && (n <= 30);
        mb = (n >= 13 && n <= 16) || n >= 39;
        cl = pl ? (n <= 24 ? 3'h3 : n <= 26 ? 3'h2 : 3'h4) : (mb || n == 17) ? 3'h2 : n == 31 ? 3'h4 : 3'h1;
        at = (pl || n == 31) ? 2'h2 : mb ? 2'h3 : 2'h1;
        pre = pl ? 24'hF96010 : mb ? 24'hFD6010 : 24'hF56010;
        return {pre, 2'h0, n[5:0], c, 12'h0, pl ? 3'h2 : 3'h1, 1'b0, cl, 2'h0, at, 2'h0, n[5:0]};
    endfunction
    // Wait for a report, read id then report, then status
    task automatic take(input int n, input logic c);
        int i;
        logic [63:0] e;
        logic pl;
        pl = (n >= 19) && (n <= 30);
        for (i = 0; i < 50 && pend !== 1'b1; i++) @(posedge clk);
        if (i == 50) begin
            miscompares++;
            tally_and_finish();
        end
        e = exp_rep(n, c);
        bus(1'b0, 4'h5, 32'h0);
        chk("event id", d, e[63:32]);
        bus(1'b0, 4'h4, 32'h0);
        chk("report", d, e[31:0]);
        bus(1'b0, 4'h1, 32'h0);
        chk("status", d, {29'h0, c, c & pl, c & !pl});
        chk("lamp pins", {grp, p_lamp, s_lamp}, {c, c & pl, c & !pl});
        bus(1'b0, n > 32 ? 4'h3 : 4'h2, 32'h0);
        chk("fault flag", 32'(d[(n - 1) % 32]), 32'(c));
    endtask
    // Drive one fault on or off; 27, 29 and 30 come from the comparators
    task automatic drive(input int n, input logic v);
        @(posedge clk);
        case (n)
            27: dens <= v ? 16'h0010 : 16'h0200;
            29: spread <= v ? 16'h0200 : 16'h0000;
            30: offs <= v ? 16'h0200 : 16'h0000;
            default: fault[n - 1] <= v;
        endcase
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        fault = 40'h0;
        {dens, spread, offs} = {16'h0200, 32'h0};
        {h_evt, h_code} = 7'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl reset", d, 32'h1);
        bus(1'b0, 4'h7, 32'h0);
        chk("spread limit reset", d, 32'hFFFF);
        bus(1'b0, 4'hF, 32'h0);
        chk("unmapped", d, 32'h0);
        for (int a = 6; a <= 8; a++) bus(1'b1, a[3:0], 32'h0100);
        for (int n = 1; n <= 40; n++) begin
            if (n == 36) continue;
            drive(n, 1'b1);
            take(n, 1'b1);
            drive(n, 1'b0);
            take(n, 1'b0);
        end
        // Two handling events one idle cycle apart: second is lost
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            h_evt <= !k[0];
            h_code <= 6'h05;
        end
        bus(1'b0, 4'h5, 32'h0);
        chk("handling id", d, 32'hF7601005);
        bus(1'b0, 4'h4, 32'h0);
        chk("handling report", d, 32'h80043205);
        take(36, 1'b1);
        bus(1'b1, 4'h0, 32'h3);
        take(36, 1'b0);
        tally_and_finish();
    end
endmodule // dec_top_tb
bind dec_top dec_monitor #(.NUM_FAULTS(NUM_FAULTS)) mon_u (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
    .FAULT_IN(FAULT_IN), .HANDLING_EVT_IN(HANDLING_EVT_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .SENSOR_LAMP_OUT(SENSOR_LAMP_OUT),
    .PLANT_LAMP_OUT(PLANT_LAMP_OUT), .GROUP_FAULT_OUT(GROUP_FAULT_OUT), .REPORT_PENDING_OUT(REPORT_PENDING_OUT));
`default_nettype wire
